// ==== rtl/hpf_regs.svh ====
// How it works
// - two nearby misses within the trigger distance start a stream prefetch.
// - track up to sixteen ascending and four descending streams at once.
// - any miss also requests the companion line of its 128-byte pair.
// - prefetches rank below demand misses; demand is served first.
// - under heavy bus demand, pending prefetches are dropped or cancelled.
// - a store miss read-for-ownership counts as a load for streams.
// - software prefetch accesses count as loads and can start streams.
// - look ahead and fill L1 from L2 before the demand access.
// - every prefetch moves one whole 64-byte line, never a partial line.
// - trigger distance defaults to 256 bytes and is set by parameter TRIG_BYTES.
`ifndef HPF_REGS_SVH
`define HPF_REGS_SVH
`define HPF_ADDR_W          32
`define HPF_LINE_BYTES      64
`define HPF_LINE_SHIFT      6
`define HPF_SECTOR_BYTES    128
`define HPF_TRIG_DIST_BYTES 256
`define HPF_UP_STREAMS      16
`define HPF_DN_STREAMS      4
`define HPF_OUT_N           4
`define HPF_STAMP_W         8
`endif

// ==== rtl/hpf_pkg.sv ====
`default_nettype none
package hpf_pkg;
`include "hpf_regs.svh"
    typedef logic [`HPF_ADDR_W-`HPF_LINE_SHIFT-1:0] hpf_line_t;
    typedef enum logic [1:0] {
        HPF_LOAD,
        HPF_RFO,
        HPF_SWPF
    } hpf_kind_t;
    typedef struct packed {
        logic                   valid;
        hpf_kind_t              kind;
        logic                   l2_hit;
        logic [`HPF_ADDR_W-1:0] addr;
    } hpf_acc_t;
    typedef struct packed {
        logic      valid;
        hpf_line_t line;
    } hpf_line_req_t;
    typedef enum {
        HPF_IDLE,
        HPF_PROBE,
        HPF_ISSUE
    } hpf_state_t;
endpackage : hpf_pkg
`default_nettype wire

// ==== rtl/hpf_prefetch_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hpf_regs.svh"
module hpf_prefetch_top
    import hpf_pkg::*;
#(
    parameter int UP_N       = `HPF_UP_STREAMS,
    parameter int DN_N       = `HPF_DN_STREAMS,
    parameter int OUT_N      = `HPF_OUT_N,
    parameter int TRIG_BYTES = `HPF_TRIG_DIST_BYTES
) (
    input  wire logic          sys_clk_in,
    input  wire logic          sys_rst_in,
    input  wire hpf_acc_t      acc_in,
    input  wire logic          dem_busy_in,
    input  wire logic          busq_high_in,
    input  wire logic          bus_rdy_in,
    input  wire logic          probe_hit_in,
    input  wire hpf_line_req_t done_in,
    output var  hpf_line_req_t pf_req_out,
    output var  hpf_line_req_t probe_out,
    output var  hpf_line_req_t l1f_out
);
    localparam int N     = UP_N + DN_N;
    localparam int IDX_W = $clog2(N);
    localparam int OUT_W = (OUT_N > 1) ? $clog2(OUT_N) : 1;
    localparam hpf_line_t THR_LINES = hpf_line_t'(TRIG_BYTES / `HPF_LINE_BYTES);
    if (UP_N < 1 || DN_N < 1 || OUT_N < 1 || TRIG_BYTES < `HPF_LINE_BYTES) begin : g_bad_param
        $error("hpf_prefetch_top: unsupported parameter values");
    end
    ////////////////////////////////////////////////////////////////////////////
    // stream table: entries 0..UP_N-1 ascend, the rest descend
    logic                    st_val_r   [N];
    hpf_line_t               st_last_r  [N];
    logic [`HPF_STAMP_W-1:0] st_stamp_r [N];
    logic [`HPF_STAMP_W-1:0] stamp_now_r;
    logic                    prev_val_r;
    hpf_line_t               prev_line_r;
    logic                    out_val_r  [OUT_N];
    hpf_line_t               out_line_r [OUT_N];
    function automatic logic [IDX_W:0] find_match(input hpf_line_t ln, input logic up);
        logic [IDX_W:0] res;
        res = '0;
        for (int i = 0; i < N; i++) begin
            if (((i < UP_N) == up) && st_val_r[i] && !res[IDX_W]) begin
                if (up ? (ln > st_last_r[i] && ln - st_last_r[i] <= THR_LINES)
                       : (ln < st_last_r[i] && st_last_r[i] - ln <= THR_LINES)) begin
                    res = {1'b1, IDX_W'(i)};
                end
            end
        end
        return res;
    endfunction : find_match
    // free entry first, otherwise the one idle longest within its direction
    function automatic logic [IDX_W-1:0] find_victim(input logic up);
        logic [IDX_W-1:0]        vic;
        logic [`HPF_STAMP_W-1:0] best;
        logic                    got_free;
        vic      = up ? '0 : IDX_W'(UP_N);
        best     = '0;
        got_free = 1'b0;
        for (int i = 0; i < N; i++) begin
            if ((i < UP_N) == up && !got_free) begin
                if (!st_val_r[i]) begin
                    vic      = IDX_W'(i);
                    got_free = 1'b1;
                end else if (stamp_now_r - st_stamp_r[i] > best) begin
                    vic  = IDX_W'(i);
                    best = stamp_now_r - st_stamp_r[i];
                end
            end
        end
        return vic;
    endfunction : find_victim
    function automatic logic out_hit(input hpf_line_t ln);
        logic h;
        h = 1'b0;
        for (int i = 0; i < OUT_N; i++) begin
            h = h | (out_val_r[i] && out_line_r[i] == ln);
        end
        return h;
    endfunction : out_hit
    ////////////////////////////////////////////////////////////////////////////
    // access decode
    hpf_line_t        acc_line;
    logic             acc_load;
    logic             acc_miss;
    logic [IDX_W:0]   mu;
    logic [IDX_W:0]   md;
    logic             prev_near;
    logic             alloc_up;
    logic             alloc_go;
    logic [IDX_W-1:0] victim;
    logic             upd_go;
    logic [IDX_W-1:0] upd_idx;
    logic             upd_up;

    assign acc_line = acc_in.addr[`HPF_ADDR_W-1:`HPF_LINE_SHIFT];
    // rfo and software prefetch are treated exactly like loads
    assign acc_load = acc_in.valid && (acc_in.kind == HPF_LOAD || acc_in.kind == HPF_RFO
                      || acc_in.kind == HPF_SWPF);
    assign acc_miss = acc_load && !acc_in.l2_hit;
    assign mu       = find_match(acc_line, 1'b1);
    assign md       = find_match(acc_line, 1'b0);
    assign alloc_up = acc_line > prev_line_r;
    assign prev_near = prev_val_r && acc_line != prev_line_r
                       && (alloc_up ? acc_line - prev_line_r
                                    : prev_line_r - acc_line) <= THR_LINES;
    assign alloc_go = acc_miss && !mu[IDX_W] && !md[IDX_W] && prev_near;
    assign victim   = find_victim(alloc_up);
    assign upd_go   = acc_miss && (mu[IDX_W] || md[IDX_W] || prev_near);
    assign upd_idx  = mu[IDX_W] ? mu[IDX_W-1:0] : md[IDX_W] ? md[IDX_W-1:0] : victim;
    assign upd_up   = mu[IDX_W] || (!md[IDX_W] && alloc_up);

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            stamp_now_r <= '0;
            for (int i = 0; i < N; i++) begin
                st_val_r[i]   <= 1'b0;
                st_last_r[i]  <= '0;
                st_stamp_r[i] <= '0;
            end
        end else begin
            stamp_now_r <= stamp_now_r + 1'b1;
            if (upd_go) begin
                st_val_r[upd_idx]   <= 1'b1;
                st_last_r[upd_idx]  <= acc_line;
                st_stamp_r[upd_idx] <= stamp_now_r;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            prev_val_r  <= 1'b0;
            prev_line_r <= '0;
        end else if (acc_miss) begin
            prev_val_r  <= 1'b1;
            prev_line_r <= acc_line;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending candidates; a newer candidate overwrites an older one
    hpf_line_req_t strm_pend_r;
    hpf_line_req_t adj_pend_r;
    hpf_state_t    state_r;
    hpf_line_t     cand_r;
    logic          take_strm;
    logic          take_adj;
    logic          out_full;

    always_comb begin
        out_full = 1'b1;
        for (int i = 0; i < OUT_N; i++) begin
            out_full = out_full & out_val_r[i];
        end
    end
    assign take_strm = state_r == HPF_IDLE && !busq_high_in && !out_full && strm_pend_r.valid;
    assign take_adj  = state_r == HPF_IDLE && !busq_high_in && !out_full
                       && !strm_pend_r.valid && adj_pend_r.valid;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            strm_pend_r <= '0;
            adj_pend_r  <= '0;
        end else begin
            if (busq_high_in || take_strm) strm_pend_r.valid <= 1'b0;
            if (busq_high_in || take_adj) adj_pend_r.valid <= 1'b0;
            // a new candidate wins over the clear in the same cycle
            if (upd_go && !busq_high_in) begin
                strm_pend_r.valid <= 1'b1;
                strm_pend_r.line  <= upd_up ? acc_line + 1'b1 : acc_line - 1'b1;
            end
            if (acc_miss && !busq_high_in) begin
                adj_pend_r.valid <= 1'b1;
                adj_pend_r.line  <= {acc_line[$bits(hpf_line_t)-1:1], ~acc_line[0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // issue engine: probe L2, filter, then offer to the bus queue
    logic             accept;
    logic [OUT_W-1:0] free_idx;
    assign accept = state_r == HPF_ISSUE && pf_req_out.valid && bus_rdy_in && !busq_high_in;

    always_comb begin
        free_idx = '0;
        for (int i = OUT_N - 1; i >= 0; i--) begin
            if (!out_val_r[i]) free_idx = OUT_W'(i);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_r    <= HPF_IDLE;
            cand_r     <= '0;
            probe_out  <= '0;
            pf_req_out <= '0;
        end else begin
            case (state_r)
                HPF_IDLE: begin
                    if (take_strm || take_adj) begin
                        cand_r          <= take_strm ? strm_pend_r.line : adj_pend_r.line;
                        probe_out.valid <= 1'b1;
                        probe_out.line  <= take_strm ? strm_pend_r.line : adj_pend_r.line;
                        state_r         <= HPF_PROBE;
                    end
                end
                HPF_PROBE: begin
                    probe_out.valid <= 1'b0;
                    if (probe_hit_in || out_hit(cand_r) || busq_high_in) begin
                        state_r <= HPF_IDLE;
                    end else begin
                        pf_req_out.valid <= !dem_busy_in;
                        pf_req_out.line  <= cand_r;
                        state_r          <= HPF_ISSUE;
                    end
                end
                HPF_ISSUE: begin
                    if (busq_high_in || accept) begin
                        pf_req_out.valid <= 1'b0;
                        state_r          <= HPF_IDLE;
                    end else begin
                        pf_req_out.valid <= !dem_busy_in;
                    end
                end
                default: state_r <= HPF_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < OUT_N; i++) begin
                out_val_r[i]  <= 1'b0;
                out_line_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < OUT_N; i++) begin
                if (done_in.valid && out_val_r[i] && out_line_r[i] == done_in.line)
                    out_val_r[i] <= 1'b0;
            end
            if (accept) begin
                out_val_r[free_idx]  <= 1'b1;
                out_line_r[free_idx] <= cand_r;
            end
        end
    end

    // look-ahead L1 fill on an L2 hit, in the direction of a matching stream
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            l1f_out <= '0;
        end else begin
            l1f_out.valid <= acc_load && acc_in.l2_hit;
            l1f_out.line  <= (md[IDX_W] && !mu[IDX_W]) ? acc_line - 1'b1 : acc_line + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [IDX_W-1:0] vic_q;
    always_ff @(posedge sys_clk_in) vic_q <= victim;

    a_two_miss_start: assert property (alloc_go && !busq_high_in |=> strm_pend_r.valid
        && st_val_r[vic_q]) else $error("stream not started after two near misses");
    a_up_dir_range: assert property (mu[IDX_W] |-> mu[IDX_W-1:0] < IDX_W'(UP_N))
        else $error("ascending match outside ascending entries");
    a_adj_pair_line: assert property (acc_miss && !busq_high_in |=> adj_pend_r.valid
        && adj_pend_r.line == ($past(acc_line) ^ hpf_line_t'(1)))
        else $error("companion line not requested");
    a_demand_first: assert property ($rose(pf_req_out.valid) |-> !$past(dem_busy_in))
        else $error("prefetch offered while demand waiting");
    a_high_cancel: assert property (busq_high_in |=> !pf_req_out.valid && !strm_pend_r.valid
        && !adj_pend_r.valid) else $error("prefetch kept under heavy demand");
    a_rfo_as_load: assert property (acc_in.valid && acc_in.kind == HPF_RFO && !acc_in.l2_hit
        |=> prev_val_r && prev_line_r == $past(acc_line))
        else $error("rfo miss not tracked");
    a_swpf_as_load: assert property (acc_in.valid && acc_in.kind == HPF_SWPF && !acc_in.l2_hit
        |=> prev_val_r && prev_line_r == $past(acc_line))
        else $error("software prefetch miss not tracked");
    a_l1_lookahead: assert property (acc_load && acc_in.l2_hit && !md[IDX_W]
        |=> l1f_out.valid && l1f_out.line == $past(acc_line) + 1'b1)
        else $error("l1 look-ahead missing");
    a_probe_before: assert property ($rose(pf_req_out.valid) && $past(state_r) == HPF_PROBE
        |-> $past(probe_out.valid) && !$past(probe_hit_in)
        && pf_req_out.line == $past(probe_out.line))
        else $error("request not filtered by probe");
    a_lru_replace: assert property (alloc_go |=> st_last_r[vic_q] == $past(acc_line))
        else $error("victim entry not replaced");

    c_stream_alloc: cover property (alloc_go);
    c_pf_accepted: cover property (accept);
    c_pf_cancelled: cover property (pf_req_out.valid && busq_high_in);
endmodule : hpf_prefetch_top
`default_nettype wire

// ==== testbench/hpf_busq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpf_busq_model
    import hpf_pkg::*;
#(
    parameter int DONE_DLY = 5
) (
    input  wire logic          sys_clk_in,
    input  wire logic          sys_rst_in,
    input  wire logic          stall_in,
    input  wire logic          busq_high_in,
    input  wire hpf_line_req_t pf_req_in,
    input  wire hpf_line_req_t probe_in,
    output var  logic          bus_rdy_out,
    output var  logic          probe_hit_out,
    output var  hpf_line_req_t done_out
);
    bit        present [hpf_line_t];
    hpf_line_t inflight [$];
    int        age = 0;
    logic      junk_r = 1'b0;

    initial begin
        done_out = '0;
    end

    assign bus_rdy_out = !stall_in;

    // no probe up: the answer wire wanders so a stale value is never trusted
    always @* begin
        probe_hit_out = probe_in.valid ? (present.exists(probe_in.line) != 0) : junk_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // a line counts as present in l2 only once its fill has completed
    always @(posedge sys_clk_in) begin
        junk_r <= ~junk_r;
        done_out <= '{valid: 1'b0, line: ~done_out.line};
        if (sys_rst_in) begin
            inflight.delete();
            age = 0;
        end else begin
            if (pf_req_in.valid && bus_rdy_out && !busq_high_in) begin
                inflight.push_back(pf_req_in.line);
            end
            if (inflight.size() != 0) begin
                age++;
            end
            if (age >= DONE_DLY) begin
                done_out <= '{valid: 1'b1, line: inflight[0]};
                present[inflight[0]] = 1'b1;
                void'(inflight.pop_front());
                age = 0;
            end
        end
    end
endmodule : hpf_busq_model
`default_nettype wire

// ==== testbench/test_hpf_prefetch_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module test_hpf_prefetch_top
    import hpf_pkg::*;
;
    logic          sys_clk_in   = 1'b0;
    logic          sys_rst_in   = 1'b1;
    hpf_acc_t      acc_in       = '0;
    logic          dem_busy_in  = 1'b0;
    logic          busq_high_in = 1'b0;
    logic          rnd_on       = 1'b0;
    logic          hold_stall   = 1'b0;
    logic          bus_stall    = 1'b0;
    logic          dem_d        = 1'b0;
    logic          bus_rdy_in;
    logic          probe_hit_in;
    hpf_line_req_t done_in;
    hpf_line_req_t pf_req_out;
    hpf_line_req_t probe_out;
    hpf_line_req_t l1f_out;
    hpf_line_t     exp_pf [$];
    hpf_line_t     exp_l1 [$];
    hpf_line_t     e_pf;
    hpf_line_t     e_l1;
    logic [31:0]   rng          = 32'h15;
    int            errors       = 0;
    int            n_checks     = 0;

    hpf_prefetch_top u_hpf_prefetch_top (
        .sys_clk_in   (sys_clk_in),
        .sys_rst_in   (sys_rst_in),
        .acc_in       (acc_in),
        .dem_busy_in  (dem_busy_in),
        .busq_high_in (busq_high_in),
        .bus_rdy_in   (bus_rdy_in),
        .probe_hit_in (probe_hit_in),
        .done_in      (done_in),
        .pf_req_out   (pf_req_out),
        .probe_out    (probe_out),
        .l1f_out      (l1f_out)
    );

    hpf_busq_model u_hpf_busq_model (
        .sys_clk_in    (sys_clk_in),
        .sys_rst_in    (sys_rst_in),
        .stall_in      (bus_stall),
        .busq_high_in  (busq_high_in),
        .pf_req_in     (pf_req_out),
        .probe_in      (probe_out),
        .bus_rdy_out   (bus_rdy_in),
        .probe_hit_out (probe_hit_in),
        .done_out      (done_in)
    );

    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////
    // random byte offset inside the line must not change which line is fetched
    task automatic acc(input hpf_line_t ln, input hpf_kind_t k, input logic hit);
        logic [31:0] r;
        r = xs();
        @(negedge sys_clk_in);
        acc_in <= '{valid: 1'b1, kind: k, l2_hit: hit, addr: {ln, r[5:0]}};
        @(negedge sys_clk_in);
        acc_in.valid <= 1'b0;
    endtask : acc

    task automatic settle();
        int i;
        for (i = 0; i < 300 && (exp_pf.size() + exp_l1.size() != 0); i++) begin
            @(negedge sys_clk_in);
        end
        if (i == 300) begin
            errors++;
            end_of_test();
        end
        repeat (14) @(negedge sys_clk_in);
    endtask : settle

    task automatic step(input hpf_line_t ln, input hpf_kind_t k, input logic hit,
                        input logic has_exp, input hpf_line_t ex);
        if (has_exp && hit) begin
            exp_l1.push_back(ex);
        end else if (has_exp) begin
            exp_pf.push_back(ex);
        end
        acc(ln, k, hit);
        settle();
    endtask : step

    always @(negedge sys_clk_in) begin
        bus_stall <= hold_stall | (rnd_on & (xs() % 3 == 0));
    end

    ////////////////////////////////////////////////////////////////////////////
    // watcher: every accepted request and every l1 fill takes the oldest note
    always @(posedge sys_clk_in) begin
        dem_d <= dem_busy_in;
        if (dem_d) `CHK("pf_valid_in_demand", 1'b0, pf_req_out.valid)
        if (pf_req_out.valid === 1'b1 && bus_rdy_in && !busq_high_in) begin
            e_pf = exp_pf.size() != 0 ? exp_pf.pop_front() : ~pf_req_out.line;
            `CHK("pf_line", e_pf, pf_req_out.line)
        end
        if (l1f_out.valid === 1'b1) begin
            e_l1 = exp_l1.size() != 0 ? exp_l1.pop_front() : ~l1f_out.line;
            `CHK("l1_fill_line", e_l1, l1f_out.line)
        end
    end

    initial begin
        int i;
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        sys_rst_in <= 1'b0;
        `CHK("idle_after_reset", 1'b0, pf_req_out.valid | probe_out.valid | l1f_out.valid)
        rnd_on <= 1'b1;
        step(26'h100, HPF_LOAD, 1'b0, 1'b1, 26'h101);
        step(26'h200, HPF_RFO, 1'b0, 1'b1, 26'h201);
        step(26'h204, HPF_RFO, 1'b0, 1'b1, 26'h205);
        step(26'h400, HPF_SWPF, 1'b0, 1'b1, 26'h401);
        step(26'h402, HPF_SWPF, 1'b0, 1'b1, 26'h403);
        step(26'h50A, HPF_LOAD, 1'b0, 1'b1, 26'h50B);
        step(26'h507, HPF_LOAD, 1'b0, 1'b1, 26'h506);
        step(26'h300, HPF_LOAD, 1'b0, 1'b1, 26'h301);
        step(26'h305, HPF_LOAD, 1'b0, 1'b1, 26'h304);
        step(26'h100, HPF_LOAD, 1'b0, 1'b0, 26'h0);
        step(26'h600, hpf_kind_t'(2'h3), 1'b0, 1'b0, 26'h0);
        step(26'h700, HPF_LOAD, 1'b1, 1'b1, 26'h701);
        // stall the queue so the offer stands, then let demand push it back
        rnd_on <= 1'b0;
        hold_stall <= 1'b1;
        exp_pf.push_back(26'hA01);
        acc(26'hA00, HPF_LOAD, 1'b0);
        for (i = 0; i < 50 && pf_req_out.valid !== 1'b1; i++) begin
            @(negedge sys_clk_in);
        end
        `CHK("pf_offered", 1'b1, pf_req_out.valid)
        dem_busy_in <= 1'b1;
        repeat (6) @(negedge sys_clk_in);
        hold_stall <= 1'b0;
        repeat (4) @(negedge sys_clk_in);
        dem_busy_in <= 1'b0;
        settle();
        busq_high_in <= 1'b1;
        acc(26'h900, HPF_LOAD, 1'b0);
        repeat (6) @(negedge sys_clk_in);
        busq_high_in <= 1'b0;
        settle();
        `CHK("notes_left", 0, exp_pf.size() + exp_l1.size())
        end_of_test();
    end
endmodule : test_hpf_prefetch_top
`default_nettype wire
